// ---- design/dcr_pkg.sv ----
// Constants of the device configuration register bank: offsets, field
// positions, reset values and reload sweep bounds.
// Assumes an 8-bit register address space reached through the serial engine.
package dcr_pkg;

  localparam int          DCR_AW            = 8;
  localparam int          DCR_DW            = 8;

  localparam logic [7:0]  DCR_OFS_DEV_CTRL  = 8'h00;
  localparam logic [7:0]  DCR_OFS_ADDR_RB   = 8'h01;
  localparam logic [7:0]  DCR_OFS_IO_LEVEL  = 8'h1F;

  localparam logic [7:0]  DCR_RELOAD_FIRST  = 8'h02;
  localparam logic [7:0]  DCR_RELOAD_LAST   = 8'hFF;

  localparam int          DCR_BIT_RELOAD    = 0;
  localparam int          DCR_BIT_FOUR_WIRE = 1;
  localparam int          DCR_BIT_HOST_LVL  = 0;
  localparam int          DCR_BIT_STAT_LVL  = 1;

  localparam logic        DCR_RST_FOUR_WIRE = 1'b0;
  localparam logic        DCR_RST_HOST_LVL  = 1'b0;
  localparam logic        DCR_RST_STAT_LVL  = 1'b1;
  localparam logic [7:0]  DCR_RST_GENERAL   = 8'h00;

  localparam logic [4:0]  DCR_ADDR_PREFIX   = 5'b11011;

  typedef enum logic [0:0] {
    DCR_ST_RELOAD,
    DCR_ST_RUN
  } dcr_state_t;

endpackage : dcr_pkg

// ---- design/dcr_cfg_mem.sv ----
// Byte-wide register storage for the reloadable part of the register map.
// Assumes one writer and one reader on the same clock; read data are registered.
`timescale 1ns/100ps

module dcr_cfg_mem #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          clk,    // Core clock
  input  wire logic          we,     // Write enable
  input  wire logic [AW-1:0] waddr,  // Write address
  input  wire logic [DW-1:0] wdata,  // Write data
  input  wire logic [AW-1:0] raddr,  // Read address
  output logic      [DW-1:0] rdata   // Read data, one cycle after raddr
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // The array has no reset; the bank's reload sweep gives it its defaults.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end

endmodule : dcr_cfg_mem

// ---- design/dcr_device_config_registers.sv ----
// Device configuration register bank: control, bus address readback, I/O levels
// and storage for the reloadable register range.
// Assumes the serial interface engine runs on core_clk and presents single-cycle
// read and write strobes; strap and port type pins arrive asynchronously.
`timescale 1ns/100ps

// Function
// - Reload bit restores defaults from third address
// - Reload spares lowest two registers, serial engine
// - Address readback read-only: 11011 plus straps
// - Bit1 follows high strap, bit0 low
// - SPI port type forces strap bits zero
// - Three-wire: MOSI bidirectional, MISO high impedance
// - Four-wire: MOSI input only, MISO drives
// - Status pin level: 0 1.8V, 1 3.3V
// - Host port level: 0 1.8V, 1 3.3V
// - Writable fields reset to defaults, storage overrides all but control
// - Status valid only after power-up reset release
module dcr_device_config_registers #(
  parameter logic [7:0] GENERAL_DEFAULT = dcr_pkg::DCR_RST_GENERAL
) (
  input  wire logic                       core_clk,            // Core clock, 10 MHz
  input  wire logic                       sys_rst,             // Async reset, active high
  input  wire logic                       reg_wr_en,           // Serial engine write strobe
  input  wire logic                       reg_rd_en,           // Serial engine read strobe
  input  wire logic [dcr_pkg::DCR_AW-1:0] reg_addr,            // Register address
  input  wire logic [dcr_pkg::DCR_DW-1:0] reg_wr_data,         // Write data
  output logic      [dcr_pkg::DCR_DW-1:0] reg_rd_data,         // Read data
  output logic                            reg_rd_valid,        // Read data valid pulse
  input  wire logic                       nvm_wr_en,           // Storage load strobe during init
  input  wire logic [dcr_pkg::DCR_AW-1:0] nvm_addr,            // Storage load address
  input  wire logic [dcr_pkg::DCR_DW-1:0] nvm_data,            // Storage load data
  input  wire logic                       nvm_done,            // Storage load finished
  input  wire logic                       address_strap_high,  // High address strap pin
  input  wire logic                       address_strap_low,   // Low address strap pin
  input  wire logic                       port_type_select,    // Pin: 0 I2C, 1 SPI
  input  wire logic                       spi_tx_active,       // Engine is shifting read data
  input  wire logic                       spi_tx_bit,          // Engine read data bit
  output logic                            mosi_out,            // MOSI output value
  output logic                            mosi_oe,             // MOSI output enable
  output logic                            miso_out,            // MISO output value
  output logic                            miso_oe,             // MISO output enable
  output logic                            four_wire_select,    // Four-wire SPI mode
  output logic                            status_pin_level_3v3, // Lock and interrupt pins at 3.3V
  output logic                            host_port_level_3v3, // Serial port outputs at 3.3V
  output logic                            reload_busy,         // Reload sweep running
  output logic                            status_valid         // Status bits may be trusted
);

  import dcr_pkg::*;

  dcr_state_t        state_q;
  logic [DCR_AW-1:0] sweep_ptr_q;
  logic              soft_reload_q;
  logic              init_done_q;
  logic [1:0]        strap_hi_sync_q;
  logic [1:0]        strap_lo_sync_q;
  logic [1:0]        port_sync_q;
  logic [DCR_AW-1:0] rd_addr_q;
  logic              rd_pend_q;
  logic              mem_we;
  logic [DCR_AW-1:0] mem_waddr;
  logic [DCR_DW-1:0] mem_wdata;
  logic [DCR_DW-1:0] mem_rdata;
  logic [DCR_DW-1:0] addr_rb;
  logic              wr_ctrl;
  logic              wr_io;
  logic              wr_general;

  assign wr_ctrl    = reg_wr_en && (reg_addr == DCR_OFS_DEV_CTRL);
  assign wr_io      = reg_wr_en && (reg_addr == DCR_OFS_IO_LEVEL) && (state_q == DCR_ST_RUN);
  // Writes into the reloadable range are dropped while the sweep owns the memory.
  assign wr_general = reg_wr_en && (reg_addr >= DCR_RELOAD_FIRST) && (state_q == DCR_ST_RUN);

  // Pins are synchronised; only the second stage is used.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_hi_sync_q <= 2'h0;
      strap_lo_sync_q <= 2'h0;
      port_sync_q     <= 2'h0;
    end else begin
      strap_hi_sync_q <= {strap_hi_sync_q[0], address_strap_high};
      strap_lo_sync_q <= {strap_lo_sync_q[0], address_strap_low};
      port_sync_q     <= {port_sync_q[0], port_type_select};
    end
  end

  // Reset enters the sweep too, so the memory comes up at its defaults.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q     <= DCR_ST_RELOAD;
      sweep_ptr_q <= DCR_RELOAD_FIRST;
    end else begin
      case (state_q)
        DCR_ST_RELOAD: begin
          if (sweep_ptr_q == DCR_RELOAD_LAST) begin
            state_q <= DCR_ST_RUN;
          end else begin
            sweep_ptr_q <= sweep_ptr_q + 8'h01;
          end
        end
        DCR_ST_RUN: begin
          if (soft_reload_q) begin
            state_q     <= DCR_ST_RELOAD;
            sweep_ptr_q <= DCR_RELOAD_FIRST;
          end
        end
        default: state_q <= DCR_ST_RUN;
      endcase
    end
  end

  always_comb begin
    if (state_q == DCR_ST_RELOAD) begin
      mem_we    = 1'b1;
      mem_waddr = sweep_ptr_q;
      mem_wdata = GENERAL_DEFAULT;
    end else if (nvm_wr_en && !init_done_q && (nvm_addr >= DCR_RELOAD_FIRST)) begin
      mem_we    = 1'b1;
      mem_waddr = nvm_addr;
      mem_wdata = nvm_data;
    end else begin
      mem_we    = wr_general;
      mem_waddr = reg_addr;
      mem_wdata = reg_wr_data;
    end
  end

  dcr_cfg_mem #(
    .AW (DCR_AW),
    .DW (DCR_DW)
  ) u_mem (
    .clk   (core_clk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (reg_addr),
    .rdata (mem_rdata)
  );

  // Device control register: set by reset and writes; the sweep only clears the reload bit at its end.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      soft_reload_q    <= 1'b0;
      four_wire_select <= DCR_RST_FOUR_WIRE;
    end else begin
      if (wr_ctrl) begin
        four_wire_select <= reg_wr_data[DCR_BIT_FOUR_WIRE];
      end
      if (wr_ctrl && reg_wr_data[DCR_BIT_RELOAD]) begin
        soft_reload_q <= 1'b1;
      end else if ((state_q == DCR_ST_RELOAD) && (sweep_ptr_q == DCR_RELOAD_LAST)) begin
        soft_reload_q <= 1'b0;
      end
    end
  end

  // I/O level register sits in the reloaded range and returns to its defaults.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_pin_level_3v3 <= DCR_RST_STAT_LVL;
      host_port_level_3v3  <= DCR_RST_HOST_LVL;
    end else if (state_q == DCR_ST_RELOAD) begin
      status_pin_level_3v3 <= DCR_RST_STAT_LVL;
      host_port_level_3v3  <= DCR_RST_HOST_LVL;
    end else if (nvm_wr_en && !init_done_q && (nvm_addr == DCR_OFS_IO_LEVEL)) begin
      status_pin_level_3v3 <= nvm_data[DCR_BIT_STAT_LVL];
      host_port_level_3v3  <= nvm_data[DCR_BIT_HOST_LVL];
    end else if (wr_io) begin
      status_pin_level_3v3 <= reg_wr_data[DCR_BIT_STAT_LVL];
      host_port_level_3v3  <= reg_wr_data[DCR_BIT_HOST_LVL];
    end
  end

  // Status is trusted once reset is released, the sweep is over and the power-up load has ended.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_done_q  <= 1'b0;
      status_valid <= 1'b0;
      reload_busy  <= 1'b1;
    end else begin
      if (nvm_done && (state_q == DCR_ST_RUN)) begin
        init_done_q <= 1'b1;
      end
      status_valid <= init_done_q;
      reload_busy  <= (state_q == DCR_ST_RELOAD) || soft_reload_q;
    end
  end

  always_comb begin
    addr_rb = {1'b0, DCR_ADDR_PREFIX, 2'b00};
    if (!port_sync_q[1]) begin
      addr_rb[1] = strap_hi_sync_q[1];
      addr_rb[0] = strap_lo_sync_q[1];
    end
  end

  // Read path waits one cycle so the memory's registered output lines up.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_addr_q    <= 8'h00;
      rd_pend_q    <= 1'b0;
      reg_rd_data  <= 8'h00;
      reg_rd_valid <= 1'b0;
    end else begin
      rd_addr_q    <= reg_addr;
      rd_pend_q    <= reg_rd_en;
      reg_rd_valid <= rd_pend_q;
      if (rd_pend_q) begin
        if (rd_addr_q == DCR_OFS_DEV_CTRL) begin
          reg_rd_data <= {6'h00, four_wire_select, soft_reload_q};
        end else if (rd_addr_q == DCR_OFS_ADDR_RB) begin
          reg_rd_data <= addr_rb;
        end else if (rd_addr_q == DCR_OFS_IO_LEVEL) begin
          reg_rd_data <= {6'h00, status_pin_level_3v3, host_port_level_3v3};
        end else begin
          reg_rd_data <= mem_rdata;
        end
      end
    end
  end

  // Data pin steering by the wire mode.
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mosi_out <= 1'b0;
      mosi_oe  <= 1'b0;
      miso_out <= 1'b0;
      miso_oe  <= 1'b0;
    end else if (four_wire_select) begin
      mosi_out <= 1'b0;
      mosi_oe  <= 1'b0;
      miso_out <= spi_tx_bit;
      miso_oe  <= spi_tx_active;
    end else begin
      mosi_out <= spi_tx_bit;
      mosi_oe  <= spi_tx_active;
      miso_out <= 1'b0;
      miso_oe  <= 1'b0;
    end
  end

endmodule : dcr_device_config_registers

// ---- verification/dcr_assertions.sv ----
// Checker for the configuration register bank, bound to its top module.
// Assumes single-cycle strobes from the serial engine and one clock.
`timescale 1ns/100ps
module dcr_assertions (
  input wire logic       core_clk,             // Clock
  input wire logic       sys_rst,              // Reset
  input wire logic       reg_wr_en,            // Write strobe
  input wire logic       reg_rd_en,            // Read strobe
  input wire logic [7:0] reg_addr,             // Address
  input wire logic [7:0] reg_wr_data,          // Write data
  input wire logic       reg_rd_valid,         // Read valid
  input wire logic       spi_tx_active,        // Shifting
  input wire logic       spi_tx_bit,           // Shift bit
  input wire logic       mosi_out,             // MOSI value
  input wire logic       mosi_oe,              // MOSI enable
  input wire logic       miso_out,             // MISO value
  input wire logic       miso_oe,              // MISO enable
  input wire logic       four_wire_select,     // Four-wire mode
  input wire logic       status_pin_level_3v3, // Status level
  input wire logic       host_port_level_3v3,  // Host level
  input wire logic       reload_busy           // Sweep running
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  rd_latency_a: assert property (reg_rd_en |-> ##2 reg_rd_valid) else $error("read valid late");
  reload_span_a: assert property (reg_wr_en && reg_addr == 8'h00 && reg_wr_data[0] && !reload_busy |->
    ##2 reload_busy [*8] ##247 reload_busy ##1 !reload_busy) else $error("reload length wrong");
  reload_dflt_a: assert property ($fell(reload_busy) |-> status_pin_level_3v3 && !host_port_level_3v3)
    else $error("levels not restored");
  miso_hiz_a: assert property (!four_wire_select && !$past(four_wire_select) |-> !miso_oe)
    else $error("MISO driven in three-wire");
  mosi_drive_a: assert property ($past(spi_tx_active) && !$past(four_wire_select) |->
    mosi_oe && mosi_out == $past(spi_tx_bit)) else $error("MOSI not driving");
  miso_drive_a: assert property ($past(spi_tx_active) && $past(four_wire_select) |->
    miso_oe && !mosi_oe && miso_out == $past(spi_tx_bit)) else $error("MISO not driving");
  io_level_a: assert property (reg_wr_en && reg_addr == 8'h1F && !reload_busy |=>
    {status_pin_level_3v3, host_port_level_3v3} == $past(reg_wr_data[1:0])) else $error("level wrong");
  four_wire_a: assert property (reg_wr_en && reg_addr == 8'h00 |=>
    four_wire_select == $past(reg_wr_data[1])) else $error("mode bit wrong");
  cover property (reg_rd_valid);
  cover property ($fell(reload_busy));
  cover property (miso_oe);
endmodule : dcr_assertions

bind dcr_device_config_registers dcr_assertions u_chk (.core_clk, .sys_rst, .reg_wr_en, .reg_rd_en, .reg_addr,
  .reg_wr_data, .reg_rd_valid, .spi_tx_active, .spi_tx_bit, .mosi_out, .mosi_oe, .miso_out, .miso_oe,
  .four_wire_select, .status_pin_level_3v3, .host_port_level_3v3, .reload_busy);

// ---- verification/dcr_host_model.sv ----
// Host side model: serial engine strobes and a random read data shifter.
// Assumes the bench calls wr and rd from one process only.
`timescale 1ns/100ps
module dcr_host_model (
  input  wire logic       core_clk,      // Clock
  input  wire logic       sys_rst,       // Keeps the shifter quiet in reset
  input  wire logic       reg_rd_valid,  // Read valid
  input  wire logic [7:0] reg_rd_data,   // Read data
  output logic            reg_wr_en,     // Write strobe
  output logic            reg_rd_en,     // Read strobe
  output logic      [7:0] reg_addr,      // Address
  output logic      [7:0] reg_wr_data,   // Write data
  output logic            spi_tx_active, // Shifting
  output logic            spi_tx_bit     // Shift bit
);
  initial {reg_wr_en, reg_rd_en, reg_addr, reg_wr_data, spi_tx_active, spi_tx_bit} = '0;
  always @(posedge core_clk) begin
    spi_tx_active <= !sys_rst && ($urandom_range(1) == 1);
    spi_tx_bit    <= ($urandom_range(1) == 1);
  end
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr_en   <= 1'b1;
    reg_addr    <= a;
    reg_wr_data <= d;
    @(posedge core_clk);
    reg_wr_en   <= 1'b0;
  endtask : wr
  // Data are taken just after the edge that raises the valid pulse, one edge after the strobe is taken.
  // Waiting any longer would miss the one-cycle valid pulse; ok reports that pulse.
  task rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge core_clk);
    reg_rd_en <= 1'b1;
    reg_addr  <= a;
    @(posedge core_clk);
    reg_rd_en <= 1'b0;
    @(posedge core_clk);
    #1;
    d  = reg_rd_data;
    ok = reg_rd_valid;
  endtask : rd
endmodule : dcr_host_model

// ---- verification/tb_device_config_registers.sv ----
// Self-checking bench for the configuration register bank.
// Assumes the host model and the bound checker beside the bank.
`timescale 1ns/100ps
module tb_device_config_registers;
  import dcr_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b1, nvm_wr_en = 1'b0, nvm_done = 1'b0;
  logic h = 1'b0, l = 1'b0, pt = 1'b0, wr_en, rd_en, tx_act, tx_bit, rd_valid, ok;
  logic fw, stat_lvl, host_lvl, busy, st_valid;
  logic [7:0] nvm_addr = 8'h00, nvm_data = 8'h00, addr, wdata, rd_data, d, v, nv, g;
  int miscompares = 0, n_tests = 0, cycles = 0;
  always #50 core_clk = ~core_clk;
  dcr_host_model u_host (.core_clk, .sys_rst, .reg_rd_valid(rd_valid), .reg_rd_data(rd_data), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_addr(addr), .reg_wr_data(wdata), .spi_tx_active(tx_act), .spi_tx_bit(tx_bit));
  dcr_device_config_registers u_dut (.core_clk, .sys_rst, .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_wr_data(wdata), .reg_rd_data(rd_data), .reg_rd_valid(rd_valid), .nvm_wr_en, .nvm_addr, .nvm_data,
    .nvm_done, .address_strap_high(h), .address_strap_low(l), .port_type_select(pt), .spi_tx_active(tx_act),
    .spi_tx_bit(tx_bit), .mosi_out(), .mosi_oe(), .miso_out(), .miso_oe(), .four_wire_select(fw),
    .status_pin_level_3v3(stat_lvl), .host_port_level_3v3(host_lvl), .reload_busy(busy), .status_valid(st_valid));
  function automatic logic [7:0] exp_rb(input logic sh, input logic sl, input logic spi);
    return {1'b0, DCR_ADDR_PREFIX, spi ? 2'b00 : {sh, sl}};
  endfunction : exp_rb
  task close_out;
    $display("comparisons %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task rdc(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, d, ok);
    chk({7'h00, ok}, 8'h01);
    chk(d, exp);
  endtask : rdc
  task wait_idle;
    for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge core_clk);
    #1;
    chk({7'h00, busy}, 8'h00);
  endtask : wait_idle
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    void'($urandom(32'h966806e3));
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({6'h00, stat_lvl, host_lvl}, {6'h00, DCR_RST_STAT_LVL, DCR_RST_HOST_LVL});
    chk({7'h00, fw}, {7'h00, DCR_RST_FOUR_WIRE});
    wait_idle();
    chk({7'h00, st_valid}, 8'h00);
    nv = 8'($urandom);
    @(posedge core_clk);
    nvm_wr_en <= 1'b1;
    nvm_addr  <= 8'h50;
    nvm_data  <= nv;
    @(posedge core_clk);
    nvm_addr  <= DCR_OFS_IO_LEVEL;
    nvm_data  <= 8'h01;
    @(posedge core_clk);
    nvm_wr_en <= 1'b0;
    nvm_done  <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk({7'h00, st_valid}, 8'h01);
    chk({6'h00, stat_lvl, host_lvl}, 8'h01);
    rdc(8'h50, nv);
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      h  <= 1'($urandom_range(1));
      l  <= 1'($urandom_range(1));
      pt <= i[0];
      repeat (3) @(posedge core_clk);
      rdc(8'h01, exp_rb(h, l, pt));
    end
    u_host.wr(8'h01, 8'h00);
    rdc(8'h01, exp_rb(h, l, pt));
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      v[1:0] = i[1:0];
      u_host.wr(8'h1F, v);
      rdc(8'h1F, {6'h00, v[1:0]});
      chk({6'h00, stat_lvl, host_lvl}, {6'h00, v[1:0]});
    end
    g = 8'($urandom);
    u_host.wr(8'h40, g);
    rdc(8'h40, g);
    u_host.wr(8'h00, 8'h03);
    // The busy flag rises one edge after the reload write is taken.
    @(posedge core_clk);
    #1;
    chk({7'h00, busy}, 8'h01);
    wait_idle();
    rdc(8'h40, DCR_RST_GENERAL);
    rdc(8'h1F, {6'h00, DCR_RST_STAT_LVL, DCR_RST_HOST_LVL});
    rdc(8'h00, 8'h02);
    rdc(8'h01, exp_rb(h, l, pt));
    chk({7'h00, fw}, 8'h01);
    repeat (30) @(posedge core_clk);
    close_out();
  end
endmodule : tb_device_config_registers
